// ---- design/lcgis_pkg.sv ----
package lcgis_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int NUM_SRC = 4;
    localparam int NUM_GATE = 4;
    localparam int NUM_CAND = 8;
    localparam int SEL_W = 3;
    localparam int POOL_W = NUM_SRC * NUM_CAND;
    localparam int GATE_EN_W = 2 * NUM_SRC;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_GATE_SEL_LOW = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_GATE_SEL_HIGH = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_SRC_SEL = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_GATE_INVERT = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_GATE_STATUS = 12'h010;

    // Reset values
    localparam logic [REG_W-1:0] RST_GATE_SEL_LOW = 16'h0000;
    localparam logic [REG_W-1:0] RST_GATE_SEL_HIGH = 16'h0000;
    localparam logic [NUM_SRC*SEL_W-1:0] RST_SRC_SEL = 12'h000;
    localparam logic [NUM_GATE-1:0] RST_GATE_INVERT = 4'h0;

    // Field positions of the gate bytes inside the two select registers
    localparam int POS_GATE_LO_BYTE = 0;
    localparam int POS_GATE_HI_BYTE = 8;
    // Field positions inside a gate byte
    localparam int POS_INV_IN_PAIR = 0;
    localparam int POS_TRUE_IN_PAIR = 1;
    // Source select field spacing: 4 bits per source, 3 used
    localparam int SRC_FIELD_STRIDE = 4;
endpackage : lcgis_pkg

// ---- design/lcgis_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcgis_gate #(
    parameter int EN_W = 8
) (
    // Signals offered to the gate and their enables
    input wire logic [EN_W-1:0] gateSig,
    input wire logic [EN_W-1:0] gateEn,
    // Polarity
    input wire logic invert,
    // Result
    output logic gateRes
);
    logic orRes;

    // Empty enable set gives zero
    assign orRes = |(gateSig & gateEn);
    assign gateRes = orRes ^ invert;
endmodule : lcgis_gate
`default_nettype wire

// ---- design/lcgis_top.sv ----
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lcgis_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lcgis_pkg::ADDR_W-1:0] paddr,
    input wire logic [lcgis_pkg::DATA_W-1:0] pwdata,
    output logic [lcgis_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Candidate source pool, eight per multiplexer
    input wire logic [lcgis_pkg::POOL_W-1:0] srcCand,
    // Gate results towards the logic function
    output logic [lcgis_pkg::NUM_GATE-1:0] gateOut
);
    import lcgis_pkg::*;

    logic [REG_W-1:0] gateSelLow;
    logic [REG_W-1:0] gateSelHigh;
    logic [NUM_SRC*SEL_W-1:0] srcSel;
    logic [NUM_GATE-1:0] gateInvert;

    logic [NUM_SRC-1:0] srcTrue;
    logic [NUM_SRC-1:0] srcInv;
    logic [GATE_EN_W-1:0] gateSig;
    logic [GATE_EN_W-1:0] gateEn [NUM_GATE];
    logic [NUM_GATE-1:0] next_gateOut;

    // Bus decode
    wire hitLow = (paddr == OFF_GATE_SEL_LOW);
    wire hitHigh = (paddr == OFF_GATE_SEL_HIGH);
    wire hitSel = (paddr == OFF_SRC_SEL);
    wire hitInv = (paddr == OFF_GATE_INVERT);
    wire hitStat = (paddr == OFF_GATE_STATUS);
    wire hitRw = hitLow | hitHigh | hitSel | hitInv;
    wire mapped = hitRw | hitStat;
    wire setupPh = psel & ~penable;
    wire accessDone = psel & penable & pready;
    wire wrEn = accessDone & pwrite & hitRw;
    wire badAccess = ~mapped | (pwrite & hitStat);

    // Source select register, one 4-bit field per multiplexer
    logic [DATA_W-1:0] srcSelRead;
    logic [NUM_SRC*SEL_W-1:0] srcSelWrite;
    genvar s;
    generate
        for (s = 0; s < NUM_SRC; s++) begin : g_selmap
            assign srcSelRead[s*SRC_FIELD_STRIDE +: SRC_FIELD_STRIDE] =
                {1'b0, srcSel[s*SEL_W +: SEL_W]};
            assign srcSelWrite[s*SEL_W +: SEL_W] =
                pwdata[s*SRC_FIELD_STRIDE +: SEL_W];
        end
        for (s = NUM_SRC*SRC_FIELD_STRIDE; s < DATA_W; s++)
            begin : g_selpad
            assign srcSelRead[s] = 1'b0;
        end
    endgenerate

    wire [DATA_W-1:0] rdMux =
        hitLow ? {16'h0000, gateSelLow} :
        hitHigh ? {16'h0000, gateSelHigh} :
        hitSel ? srcSelRead :
        hitInv ? {28'h0000000, gateInvert} :
        hitStat ? {28'h0000000, gateOut} :
        32'h00000000;

    // Answer comes one cycle after setup, so every access has no wait
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setupPh;
            pslverr <= setupPh & badAccess;
            prdata <= (setupPh & ~pwrite) ? rdMux : 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            gateSelLow <= RST_GATE_SEL_LOW;
            gateSelHigh <= RST_GATE_SEL_HIGH;
            srcSel <= RST_SRC_SEL;
            gateInvert <= RST_GATE_INVERT;
        end else if (wrEn) begin
            if (hitLow) begin
                gateSelLow <= pwdata[REG_W-1:0];
            end
            if (hitHigh) begin
                gateSelHigh <= pwdata[REG_W-1:0];
            end
            if (hitSel) begin
                srcSel <= srcSelWrite;
            end
            if (hitInv) begin
                gateInvert <= pwdata[NUM_GATE-1:0];
            end
        end
    end

    // Source multiplexers over the 32-signal pool
    genvar m;
    generate
        for (m = 0; m < NUM_SRC; m++) begin : g_mux
            assign srcTrue[m] =
                srcCand[m*NUM_CAND + int'(srcSel[m*SEL_W +: SEL_W])];
            assign srcInv[m] = ~srcTrue[m];
            // Pair per source, true above inverted
            assign gateSig[2*m + POS_INV_IN_PAIR] = srcInv[m];
            assign gateSig[2*m + POS_TRUE_IN_PAIR] = srcTrue[m];
        end
    endgenerate

    // Byte to gate mapping
    assign gateEn[0] = gateSelLow[POS_GATE_LO_BYTE +: GATE_EN_W];
    assign gateEn[1] = gateSelLow[POS_GATE_HI_BYTE +: GATE_EN_W];
    assign gateEn[2] = gateSelHigh[POS_GATE_LO_BYTE +: GATE_EN_W];
    assign gateEn[3] = gateSelHigh[POS_GATE_HI_BYTE +: GATE_EN_W];

    genvar g;
    generate
        for (g = 0; g < NUM_GATE; g++) begin : g_gate
            lcgis_gate #(
                .EN_W(GATE_EN_W)
            ) u_gate (
                .gateSig(gateSig),
                .gateEn(gateEn[g]),
                .invert(gateInvert[g]),
                .gateRes(next_gateOut[g])
            );
        end
    endgenerate

    // Gate results leave through a flop, one cycle behind the sources
    always_ff @(posedge mclk) begin
        if (rst) begin
            gateOut <= 4'h0;
        end else begin
            gateOut <= next_gateOut;
        end
    end

    property p_gate1_or;
        @(posedge mclk) disable iff (rst)
        1'b1 |=> gateOut[0] == ((|($past(gateSelLow[7:0]) &
            $past(gateSig))) ^ $past(gateInvert[0]));
    endproperty
    a_gate1_or: assert property (p_gate1_or)
        else $error("gate 1 result wrong");

    property p_gate2_or;
        @(posedge mclk) disable iff (rst)
        1'b1 |=> gateOut[1] == ((|($past(gateSelLow[15:8]) &
            $past(gateSig))) ^ $past(gateInvert[1]));
    endproperty
    a_gate2_or: assert property (p_gate2_or)
        else $error("gate 2 result wrong");

    property p_gate3_or;
        @(posedge mclk) disable iff (rst)
        1'b1 |=> gateOut[2] == ((|($past(gateSelHigh[7:0]) &
            $past(gateSig))) ^ $past(gateInvert[2]));
    endproperty
    a_gate3_or: assert property (p_gate3_or)
        else $error("gate 3 result wrong");

    property p_gate4_or;
        @(posedge mclk) disable iff (rst)
        1'b1 |=> gateOut[3] == ((|($past(gateSelHigh[15:8]) &
            $past(gateSig))) ^ $past(gateInvert[3]));
    endproperty
    a_gate4_or: assert property (p_gate4_or)
        else $error("gate 4 result wrong");

    property p_src1_true_bit;
        @(posedge mclk) disable iff (rst)
        (gateSelLow[7:0] == 8'h02 && !gateInvert[0])
            |=> gateOut[0] == $past(srcTrue[0]);
    endproperty
    a_src1_true_bit: assert property (p_src1_true_bit)
        else $error("source 1 true enable misplaced");

    property p_src1_inv_bit;
        @(posedge mclk) disable iff (rst)
        (gateSelLow[7:0] == 8'h01 && !gateInvert[0])
            |=> gateOut[0] == !$past(srcTrue[0]);
    endproperty
    a_src1_inv_bit: assert property (p_src1_inv_bit)
        else $error("source 1 inverted enable misplaced");

    property p_mux_pick;
        @(posedge mclk) disable iff (rst)
        srcTrue[3] == srcCand[24 + int'(srcSel[11:9])] &&
            srcInv[3] != srcTrue[3];
    endproperty
    a_mux_pick: assert property (p_mux_pick)
        else $error("source 4 multiplexer wrong");

    property p_invert_empty;
        @(posedge mclk) disable iff (rst)
        (gateSelHigh[15:8] == 8'h00 && gateInvert[3]) |=> gateOut[3];
    endproperty
    a_invert_empty: assert property (p_invert_empty)
        else $error("gate 4 invert not applied");

    property p_empty_zero;
        @(posedge mclk) disable iff (rst)
        (gateSelHigh[7:0] == 8'h00 && !gateInvert[2]) |=> !gateOut[2];
    endproperty
    a_empty_zero: assert property (p_empty_zero)
        else $error("empty gate 3 not zero");

    property p_low_write;
        @(posedge mclk) disable iff (rst)
        (psel && penable && pready && pwrite && paddr == OFF_GATE_SEL_LOW)
            |=> gateSelLow == $past(pwdata[15:0]) ##1 pready == 1'b0;
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("low select write lost");
endmodule : lcgis_top
`default_nettype wire

// ---- testbench/tb_lcgis.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_lcgis;
    import lcgis_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [POOL_W-1:0] srcCand = 32'h0;
    logic [NUM_GATE-1:0] gateOut;
    logic [DATA_W-1:0] rdData;
    logic rdErr;
    int errTotal = 0;
    int samplesChecked = 0;
    int cycles = 0;

    always #10 mclk = ~mclk;

    lcgis_top lcgis_top_i (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .srcCand(srcCand), .gateOut(gateOut));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) check(32'h1, 32'h0);
    endtask : apb

    // Drive the pool, then let the registered gate path catch up
    task automatic drive(input logic [31:0] pool);
        @(posedge mclk);
        srcCand <= pool;
        repeat (2) @(posedge mclk);
        #1;
    endtask : drive

    task automatic t_regs;
        logic [11:0] a;
        for (int i = 0; i < 4; i++) begin
            a = 12'(4 * i);
            apb(1'b0, a, 32'h0);
            check(rdData, 32'h0);
        end
        apb(1'b1, OFF_GATE_SEL_LOW, 32'hFFFF5AC3);
        apb(1'b0, OFF_GATE_SEL_LOW, 32'h0);
        check(rdData, 32'h00005AC3);
        apb(1'b1, OFF_GATE_SEL_HIGH, 32'h1234A55A);
        apb(1'b0, OFF_GATE_SEL_HIGH, 32'h0);
        check(rdData, 32'h0000A55A);
        apb(1'b0, 12'h014, 32'h0);
        check({rdErr, rdData}, 33'h100000000);
        apb(1'b1, OFF_GATE_STATUS, 32'h0000000F);
        check({31'h0, rdErr}, 32'h1);
        apb(1'b1, OFF_GATE_SEL_LOW, 32'h0);
        apb(1'b1, OFF_GATE_SEL_HIGH, 32'h0);
        $display("t_regs done");
    endtask : t_regs

    // One enable bit at a time, both levels of its source
    task automatic t_bits;
        logic [11:0] a;
        logic [31:0] one;
        logic v;
        for (int g = 0; g < 4; g++) begin
            a = (g < 2) ? OFF_GATE_SEL_LOW : OFF_GATE_SEL_HIGH;
            for (int b = 0; b < 8; b++) begin
                apb(1'b1, a, 32'h1 << (b + 8 * (g % 2)));
                one = 32'h1 << (8 * (b / 2));
                for (int k = 0; k < 2; k++) begin
                    v = k[0];
                    drive(v ? one : ~one);
                    check(gateOut, {31'h0, (b % 2) ? v : ~v} << g);
                end
            end
            apb(1'b1, a, 32'h0);
        end
        apb(1'b1, OFF_GATE_INVERT, 32'h5);
        drive(32'hFFFFFFFF);
        check(gateOut, 32'h5);
        apb(1'b0, OFF_GATE_STATUS, 32'h0);
        check(rdData, 32'h5);
        apb(1'b1, OFF_GATE_INVERT, 32'h0);
        $display("t_bits done");
    endtask : t_bits

    // Every candidate of every multiplexer through gate 1
    task automatic t_mux;
        logic [31:0] one;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFF_GATE_SEL_LOW, 32'h1 << (2 * m + 1));
            for (int c = 0; c < 8; c++) begin
                apb(1'b1, OFF_SRC_SEL, 32'(c) << (4 * m));
                one = 32'h1 << (8 * m + c);
                drive(one);
                check(gateOut, 32'h1);
                drive(~one);
                check(gateOut, 32'h0);
            end
        end
        apb(1'b1, OFF_GATE_SEL_LOW, 32'h0);
        apb(1'b1, OFF_SRC_SEL, 32'h0);
        $display("t_mux done");
    endtask : t_mux

    // True and inverted copies together give one, or zero with the gate's invert bit set
    task automatic t_or;
        apb(1'b1, OFF_GATE_SEL_HIGH, 32'h0000FF03);
        drive(32'h00000000);
        check(gateOut, 32'hC);
        drive(32'hFFFFFFFF);
        check(gateOut, 32'hC);
        apb(1'b1, OFF_GATE_INVERT, 32'hC);
        drive(32'h0F0F0F0F);
        check(gateOut, 32'h0);
        apb(1'b1, OFF_GATE_SEL_LOW, 32'h00008000);
        drive(32'h01000000);
        check(gateOut, 32'h2);
        $display("t_or done");
    endtask : t_or

    task automatic reportAndStop;
        $display("Checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : reportAndStop

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            reportAndStop();
        end
    end

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_bits();
        t_mux();
        t_or();
        reportAndStop();
    end
endmodule : tb_lcgis
`default_nettype wire
